// File: iulf_pkg.sv
// Constants and types for the input undervoltage fault response block.
// Assumes a management controller that decodes bus commands on the same clock.
// Function
// - Keep a host-programmable 16-bit low-input fault threshold in linear volts format.
// - Action bits 7:6 equal 00: keep running without interruption.
// - Action 01: keep running for delay multiplier times one time unit.
// - Action 01: if still low after the delay, follow the retry count.
// - Action 10: disable output at once, then follow the retry count.
// - Action 11: disable output until a permitted clearing event.
// - Latched fault clears on bit clear, CLEAR_FAULTS or reset.
// - Latched fault also clears when output is commanded off then on.
// - Retry bits 5:3 equal 000: no restart, output stays off until cleared.
// - Retry 001 to 110: that many restarts, then stay off until cleared.
// - Restart attempts start one delay multiplier times time unit apart.
// - Retry 111: retry forever until commanded off or another fault.
// - Bits 2:0 give 2 to the n units, for ride-through and spacing.
// - Time unit length comes from the separate 0xD2 configuration register; this block takes it from the time_unit_cycles_i input.
package iulf_pkg;

  localparam logic [7:0] CMD_THRESHOLD    = 8'h59;
  localparam logic [7:0] CMD_ACTION       = 8'h5A;
  localparam logic [7:0] CMD_TIME_UNIT    = 8'hD2;

  localparam int ACT_MODE_HI  = 7;
  localparam int ACT_MODE_LO  = 6;
  localparam int ACT_RETRY_HI = 5;
  localparam int ACT_RETRY_LO = 3;
  localparam int ACT_DELAY_HI = 2;
  localparam int ACT_DELAY_LO = 0;

  localparam logic [1:0] MODE_IGNORE  = 2'h0;
  localparam logic [1:0] MODE_RIDE    = 2'h1;
  localparam logic [1:0] MODE_RETRY   = 2'h2;
  localparam logic [1:0] MODE_LATCH   = 2'h3;

  localparam logic [2:0] RETRY_NONE   = 3'h0;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;

  // Linear format: 5-bit signed exponent over 11-bit signed mantissa
  localparam int LIN_MANT_W = 11;
  localparam int LIN_VAL_W  = 48;

  localparam logic [15:0] THRESHOLD_RST = 16'h0000;
  localparam logic [7:0]  ACTION_RST    = 8'h80;

  typedef enum logic [2:0] {
    S_OFF,
    S_RUN,
    S_RIDE,
    S_WAIT,
    S_LATCH
  } iulf_state_t;

  typedef struct packed {
    iulf_state_t st;
    logic [15:0] thr;
    logic [7:0]  act;
    logic [15:0] sub;
    logic [7:0]  units;
    logic [2:0]  tries;
    logic        out_en;
    logic        flag;
    logic [15:0] rdata;
    logic        rvalid;
    logic        rack;
  } iulf_regs_t;

endpackage

// File: iulf_top.sv
// Input undervoltage fault detection and response state machine.
// Assumes command, measurement and control inputs come from logic on core_clk_i.
`timescale 1ns/1ps
`default_nettype none

module iulf_top
  import iulf_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        resetn_i,
  // Command port
  input  wire logic        cmd_valid_i,
  input  wire logic        cmd_write_i,
  input  wire logic [7:0]  cmd_code_i,
  input  wire logic [15:0] cmd_wdata_i,
  output logic [15:0]      cmd_rdata_o,
  output logic             cmd_rvalid_o,
  output logic             cmd_ack_o,
  // Fault clearing and control
  input  wire logic        clear_faults_i,
  input  wire logic        clear_status_bit_i,
  input  wire logic        output_on_cmd_i,
  input  wire logic        other_fault_i,
  // Measurement and timing
  input  wire logic [15:0] vin_meas_i,
  input  wire logic [15:0] time_unit_cycles_i,
  // Status
  output logic             output_enable_o,
  output logic             uv_fault_flag_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release through two flops

  logic [1:0] rst_sync_q;
  logic       rst_n;

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // Linear format to fixed point, mantissa scaled by 2^(exp+16)

  function automatic logic signed [LIN_VAL_W-1:0] lin_to_fix(input logic [15:0] v);
    logic signed [LIN_VAL_W-1:0] m;
    logic [4:0]                  sh;
    m  = LIN_VAL_W'($signed(v[LIN_MANT_W-1:0]));
    sh = {~v[15], v[14:LIN_MANT_W]};
    return m <<< sh;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  iulf_regs_t r_q;
  iulf_regs_t r_d;

  logic       uv;
  logic       clr_req;
  logic [1:0] mode;
  logic [2:0] retries;
  logic [7:0] units_m1;
  logic [15:0] unit_m1;
  logic       delay_done;

  always_comb begin
    uv       = lin_to_fix(vin_meas_i) < lin_to_fix(r_q.thr);
    clr_req  = clear_faults_i | clear_status_bit_i;
    mode     = r_q.act[ACT_MODE_HI:ACT_MODE_LO];
    retries  = r_q.act[ACT_RETRY_HI:ACT_RETRY_LO];
    units_m1 = 8'((8'h01 << r_q.act[ACT_DELAY_HI:ACT_DELAY_LO]) - 8'h01);
    // Zero unit treated as one cycle so the delay always ends
    unit_m1  = (time_unit_cycles_i == 16'h0000) ? 16'h0000
                                                : 16'(time_unit_cycles_i - 16'h0001);
    delay_done = (r_q.sub >= unit_m1) && (r_q.units == units_m1);
  end

  always_comb begin
    r_d        = r_q;
    r_d.rvalid = 1'b0;

    // Command handling
    if (cmd_valid_i) begin
      r_d.rack = 1'b1;
      if (cmd_write_i) begin
        case (cmd_code_i)
          CMD_THRESHOLD: r_d.thr = cmd_wdata_i;
          CMD_ACTION:    r_d.act = cmd_wdata_i[7:0];
          default:       r_d.rack = 1'b0;
        endcase
      end else begin
        r_d.rvalid = 1'b1;
        case (cmd_code_i)
          CMD_THRESHOLD: r_d.rdata = r_q.thr;
          CMD_ACTION:    r_d.rdata = {8'h00, r_q.act};
          default: begin
            r_d.rdata = 16'h0000;
            r_d.rack  = 1'b0;
          end
        endcase
      end
    end

    // Status flag: a new fault wins over a clear in the same cycle
    if (clr_req) begin
      r_d.flag = 1'b0;
    end
    if (uv) begin
      r_d.flag = 1'b1;
    end

    // Delay counter, shared by ride-through and retry spacing
    if (r_q.st == S_RIDE || r_q.st == S_WAIT) begin
      if (delay_done) begin
        r_d.sub   = 16'h0000;
        r_d.units = 8'h00;
      end else if (r_q.sub >= unit_m1) begin
        r_d.sub   = 16'h0000;
        r_d.units = 8'(r_q.units + 8'h01);
      end else begin
        r_d.sub = 16'(r_q.sub + 16'h0001);
      end
    end else begin
      r_d.sub   = 16'h0000;
      r_d.units = 8'h00;
    end

    case (r_q.st)
      S_OFF: begin
        r_d.out_en = 1'b0;
        r_d.tries  = 3'h0;
        if (output_on_cmd_i && !other_fault_i) begin
          r_d.st     = S_RUN;
          r_d.out_en = 1'b1;
        end
      end
      S_RUN: begin
        if (uv) begin
          case (mode)
            MODE_IGNORE: r_d.st = S_RUN;
            MODE_RIDE:   r_d.st = S_RIDE;
            MODE_RETRY: begin
              r_d.out_en = 1'b0;
              r_d.tries  = 3'h0;
              r_d.st     = (retries == RETRY_NONE) ? S_LATCH : S_WAIT;
            end
            default: begin
              r_d.out_en = 1'b0;
              r_d.st     = S_LATCH;
            end
          endcase
        end
      end
      S_RIDE: begin
        if (delay_done) begin
          if (uv) begin
            r_d.out_en = 1'b0;
            r_d.tries  = 3'h0;
            r_d.st     = (retries == RETRY_NONE) ? S_LATCH : S_WAIT;
          end else begin
            r_d.st = S_RUN;
          end
        end
      end
      S_WAIT: begin
        r_d.out_en = 1'b0;
        if (delay_done) begin
          if (!uv) begin
            r_d.out_en = 1'b1;
            r_d.st     = S_RUN;
          end else if (retries != RETRY_FOREVER) begin
            r_d.tries = 3'(r_q.tries + 3'h1);
            if (3'(r_q.tries + 3'h1) >= retries) begin
              r_d.st = S_LATCH;
            end
          end
        end
      end
      S_LATCH: begin
        r_d.out_en = 1'b0;
        if (clr_req) begin
          r_d.out_en = 1'b1;
          r_d.st     = S_RUN;
        end
      end
      default: begin
        r_d.out_en = 1'b0;
        r_d.st     = S_OFF;
      end
    endcase

    // Off command or another fault stops every response, retries included
    if (!output_on_cmd_i || other_fault_i) begin
      r_d.out_en = 1'b0;
      r_d.st     = S_OFF;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      r_q        <= '0;
      r_q.st     <= S_OFF;
      r_q.thr    <= THRESHOLD_RST;
      r_q.act    <= ACTION_RST;
    end else begin
      r_q <= r_d;
    end
  end

  assign cmd_rdata_o     = r_q.rdata;
  assign cmd_rvalid_o    = r_q.rvalid;
  assign cmd_ack_o       = r_q.rack;
  assign output_enable_o = r_q.out_en;
  assign uv_fault_flag_o = r_q.flag;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  logic run_ok;
  assign run_ok = output_on_cmd_i && !other_fault_i;

  flag_set_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    uv |=> uv_fault_flag_o) else $error("fault flag not set on low input");
  ignore_on_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    (r_q.st == S_RUN && mode == MODE_IGNORE && run_ok) |=> output_enable_o)
    else $error("ignore mode dropped output");
  ride_on_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    (r_q.st == S_RUN && uv && mode == MODE_RIDE && run_ok) |=> (r_q.st == S_RIDE)[*2]
    or (r_q.st == S_RIDE ##1 r_q.st != S_RIDE)) else $error("ride-through not entered");
  ride_out_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    (r_q.st == S_RIDE && delay_done && uv && run_ok) |=> !output_enable_o)
    else $error("output kept after ride-through");
  retry_off_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    (r_q.st == S_RUN && uv && mode == MODE_RETRY) |=> !output_enable_o)
    else $error("output not disabled at once");
  latch_go_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    (r_q.st == S_RUN && uv && mode == MODE_LATCH && run_ok) |=> r_q.st == S_LATCH)
    else $error("latch not entered");
  latch_hold_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    (r_q.st == S_LATCH && !clr_req && run_ok) |=> r_q.st == S_LATCH && !output_enable_o)
    else $error("latched fault left without clear");
  off_cmd_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    !output_on_cmd_i |=> r_q.st == S_OFF && !output_enable_o)
    else $error("off command ignored");
  // Judged on entry only: the host may rewrite the retry field while waiting
  no_retry_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    (r_q.st == S_WAIT && $past(r_q.st) != S_WAIT) |-> $past(retries) != RETRY_NONE)
    else $error("retry with code zero");
  tries_bound_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    (r_q.st == S_WAIT && retries != RETRY_FOREVER) |-> r_q.tries < retries)
    else $error("too many restart attempts");
  thr_read_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    (cmd_valid_i && !cmd_write_i && cmd_code_i == CMD_THRESHOLD)
    |=> cmd_rvalid_o && cmd_rdata_o == $past(r_q.thr)) else $error("threshold read wrong");

  latch_c: cover property (@(posedge core_clk_i) disable iff (!rst_n)
    r_q.st == S_WAIT ##1 r_q.st == S_LATCH);
  restart_c: cover property (@(posedge core_clk_i) disable iff (!rst_n)
    r_q.st == S_WAIT ##1 r_q.st == S_RUN);
  ride_back_c: cover property (@(posedge core_clk_i) disable iff (!rst_n)
    r_q.st == S_RIDE ##1 r_q.st == S_RUN);

endmodule

`default_nettype wire

// File: iulf_host.sv
// Host model: register commands, fault clears and output on/off control.
// Assumes the block's clock; every output changes at the falling edge.
`timescale 1ns/1ps
`default_nettype none
module iulf_host (
  // Clock and answers
  input  wire logic        core_clk_i,
  input  wire logic [15:0] cmd_rdata_i,
  input  wire logic        cmd_rvalid_i,
  input  wire logic        cmd_ack_i,
  // Requests and control
  output logic             cmd_valid_o,
  output logic             cmd_write_o,
  output logic [7:0]       cmd_code_o,
  output logic [15:0]      cmd_wdata_o,
  output logic             clear_faults_o,
  output logic             clear_status_bit_o,
  output logic             output_on_cmd_o
);
  initial begin
    {cmd_valid_o, cmd_write_o, clear_faults_o, clear_status_bit_o, output_on_cmd_o} = 5'h00;
    cmd_code_o = 8'h00;
    cmd_wdata_o = 16'h0000;
  end
  ////////////////////////////////////////////////////////////
  // One strobe cycle; answer read one and two cycles later
  task automatic cmd(input logic w, input logic [7:0] c, input logic [15:0] d,
                     output logic [15:0] rd, output logic ak, output logic rv);
    @(negedge core_clk_i);
    cmd_valid_o = 1'b1;
    cmd_write_o = w;
    cmd_code_o = c;
    cmd_wdata_o = d;
    @(negedge core_clk_i);
    cmd_valid_o = 1'b0;
    cmd_wdata_o = ~d;
    rv = cmd_rvalid_i;
    @(negedge core_clk_i);
    rv = rv | cmd_rvalid_i;
    rd = cmd_rdata_i;
    ak = cmd_ack_i;
  endtask
  // Clear pulse: 0 for the global clear, 1 for the single bit
  task automatic pulse(input logic bit_clr);
    @(negedge core_clk_i);
    if (bit_clr) clear_status_bit_o = 1'b1;
    else clear_faults_o = 1'b1;
    @(negedge core_clk_i);
    {clear_faults_o, clear_status_bit_o} = 2'h0;
  endtask
  // Two idle cycles so an off command is seen before the next on
  task automatic power(input logic v);
    @(negedge core_clk_i);
    output_on_cmd_o = v;
    repeat (2) @(negedge core_clk_i);
  endtask
endmodule
`default_nettype wire

// File: input_undervoltage_fault_response_test.sv
// Self-checking bench for the input undervoltage fault response block.
// Assumes iulf_host drives commands; input voltage and time unit come from here.
`timescale 1ns/1ps
`default_nettype none
module input_undervoltage_fault_response_test;
  import iulf_pkg::*;
  localparam logic [15:0] HI = 16'h0030;
  localparam logic [15:0] LO = 16'h0020;
  logic        clk = 1'b0, rst_n = 1'b0, oth = 1'b0;
  logic        vld, wr, rv, ak, clf, clb, on, ack, rvl, oe, fl;
  logic [7:0]  code;
  logic [15:0] wd, rdat, rd, vin = HI, tu = 16'h0002;
  int          err_count = 0, checks_done = 0, cyc = 0, m;
  always #12.5 clk = ~clk;
  iulf_host i_iulf_host (.core_clk_i(clk), .cmd_rdata_i(rdat), .cmd_rvalid_i(rvl),
    .cmd_ack_i(ack), .cmd_valid_o(vld), .cmd_write_o(wr), .cmd_code_o(code),
    .cmd_wdata_o(wd), .clear_faults_o(clf), .clear_status_bit_o(clb), .output_on_cmd_o(on));
  iulf_top i_iulf_top (.core_clk_i(clk), .resetn_i(rst_n), .cmd_valid_i(vld),
    .cmd_write_i(wr), .cmd_code_i(code), .cmd_wdata_i(wd), .cmd_rdata_o(rdat),
    .cmd_rvalid_o(rvl), .cmd_ack_o(ack), .clear_faults_i(clf), .clear_status_bit_i(clb),
    .output_on_cmd_i(on), .other_fault_i(oth), .vin_meas_i(vin),
    .time_unit_cycles_i(tu), .output_enable_o(oe), .uv_fault_flag_o(fl));
  ////////////////////////////////////////////////////////////
  task automatic chk1(string nm, logic e, logic g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic chk16(string nm, logic [15:0] e, logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic chkr(string nm, int lo, int hi, int v);
    checks_done++;
    if (v < lo || v > hi) begin
      err_count++;
      $display("CHECK FAILED %s exp %0d to %0d got %0d", nm, lo, hi, v);
    end
  endtask
  // Bounded wait for the output level, then judged
  task automatic wo(input logic lv, input int lim, output int n);
    n = 0;
    while (oe !== lv && n < lim) begin
      @(negedge clk);
      n++;
    end
    chk1("output_enable", lv, oe);
  endtask
  task automatic rg(input logic [7:0] c, input logic [15:0] d);
    i_iulf_host.cmd(1'b1, c, d, rd, ak, rv);
  endtask
  task automatic rdchk(input logic [7:0] c, input logic [15:0] e, input logic ea);
    i_iulf_host.cmd(1'b0, c, 16'h0000, rd, ak, rv);
    chk16("read_data", e, rd);
    chk1("ack", ea, ak);
    chk1("rvalid", 1'b1, rv);
  endtask
  task automatic restore();
    vin = HI;
    i_iulf_host.pulse(1'b0);
    wo(1'b1, 8, m);
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_regs();
    rdchk(CMD_THRESHOLD, THRESHOLD_RST, 1'b1);
    rdchk(CMD_ACTION, 16'h0080, 1'b1);
    rg(CMD_THRESHOLD, 16'h0028);
    rg(CMD_ACTION, 16'h12AB);
    rdchk(CMD_THRESHOLD, 16'h0028, 1'b1);
    rdchk(CMD_ACTION, 16'h00AB, 1'b1);
    rdchk(8'h33, 16'h0000, 1'b0);
    i_iulf_host.power(1'b1);
    wo(1'b1, 3, m);
  endtask
  task automatic t_ignore();
    rg(CMD_ACTION, 16'h0000);
    vin = LO;
    repeat (12) begin
      @(negedge clk);
      chk1("ignore_on", 1'b1, oe);
    end
    chk1("flag", 1'b1, fl);
    vin = HI;
    i_iulf_host.pulse(1'b1);
    chk1("flag", 1'b0, fl);
    oth = 1'b1;
    wo(1'b0, 2, m);
    oth = 1'b0;
    wo(1'b1, 3, m);
  endtask
  // One input level against the threshold; the clear pulse loses to a fault
  task automatic lin_chk(input logic [15:0] v, input logic e);
    vin = v;
    i_iulf_host.pulse(1'b1);
    chk1("linear_flag", e, fl);
  endtask
  // Threshold 80 x 2^-1 against inputs just below it and equal to it with other exponents
  task automatic t_linear();
    rg(CMD_THRESHOLD, {5'h1F, 11'h050});
    lin_chk({5'h01, 11'h013}, 1'b1);
    lin_chk({5'h01, 11'h014}, 1'b0);
    lin_chk({5'h1E, 11'h09F}, 1'b1);
    lin_chk({5'h1E, 11'h0A0}, 1'b0);
    chk1("linear_output", 1'b1, oe);
    rg(CMD_THRESHOLD, 16'h0028);
    vin = HI;
  endtask
  task automatic t_latch();
    rg(CMD_ACTION, 16'h00C0);
    vin = LO;
    wo(1'b0, 2, m);
    vin = HI;
    repeat (8) @(negedge clk);
    chk1("latched", 1'b0, oe);
    i_iulf_host.pulse(1'b0);
    wo(1'b1, 4, m);
    vin = LO;
    wo(1'b0, 2, m);
    vin = HI;
    i_iulf_host.pulse(1'b1);
    wo(1'b1, 4, m);
    vin = LO;
    wo(1'b0, 2, m);
    vin = HI;
    i_iulf_host.power(1'b0);
    i_iulf_host.power(1'b1);
    wo(1'b1, 6, m);
  endtask
  // Ride-through of 4 units of 2 cycles, no retry afterwards
  task automatic t_ride();
    rg(CMD_ACTION, 16'h0042);
    vin = LO;
    wo(1'b0, 14, m);
    chkr("ride_cycles", 8, 11, m);
    vin = HI;
    repeat (8) @(negedge clk);
    chk1("ride_latched", 1'b0, oe);
    restore();
  endtask
  // One-cycle dip under endless retry: restart lands one delay later
  task automatic t_time();
    for (int n = 0; n < 3; n++) begin
      for (int u = 2; u < 4; u++) begin
        rg(CMD_ACTION, {8'h00, MODE_RETRY, RETRY_FOREVER, n[2:0]});
        tu = u[15:0];
        vin = LO;
        @(negedge clk);
        vin = HI;
        wo(1'b0, 0, m);
        wo(1'b1, (u << n) + 5, m);
        chkr("retry_gap", (u << n), (u << n) + 3, m);
      end
    end
    tu = 16'h0002;
  endtask
  // Recover just before attempt r succeeds; just after it latches
  task automatic t_count();
    for (int r = 0; r < 7; r++) begin
      for (int k = (r == 0); k < 2; k++) begin
        rg(CMD_ACTION, {8'h00, MODE_RETRY, r[2:0], 3'h2});
        vin = LO;
        wo(1'b0, 2, m);
        repeat (r * 8 + (k ? 4 : -4)) @(negedge clk);
        vin = HI;
        repeat (16 * k) @(negedge clk);
        wo(logic'(k == 0), 12, m);
        restore();
      end
    end
  endtask
  // Mid-run reset clears a latched fault; registers return to reset values
  task automatic t_reset();
    rg(CMD_ACTION, 16'h00C0);
    vin = LO;
    wo(1'b0, 2, m);
    vin = HI;
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    chk1("reset_flag", 1'b0, fl);
    chk1("reset_output", 1'b0, oe);
    rst_n = 1'b1;
    // Internal reset ends two edges after release; commands wait past that
    repeat (2) @(negedge clk);
    wo(1'b1, 3, m);
    rdchk(CMD_THRESHOLD, THRESHOLD_RST, 1'b1);
    rdchk(CMD_ACTION, {8'h00, ACTION_RST}, 1'b1);
  endtask
  ////////////////////////////////////////////////////////////
  task automatic complete_run();
    if (err_count == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Whole run needs about 740 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      complete_run();
    end
  end
  initial begin
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    t_regs();
    t_ignore();
    t_linear();
    t_latch();
    t_ride();
    t_time();
    t_count();
    t_reset();
    complete_run();
  end
endmodule
`default_nettype wire
